// ==== inc/rtc_cal_pkg.sv ====
package rtc_cal_pkg;

   // Register offsets (byte addresses, one aligned word each)
   localparam logic [7:0] OFF_SECOND = 8'h00;
   localparam logic [7:0] OFF_MINUTE = 8'h04;
   localparam logic [7:0] OFF_HOUR = 8'h08;
   localparam logic [7:0] OFF_WEEKDAY = 8'h0C;
   localparam logic [7:0] OFF_DATE = 8'h10;
   localparam logic [7:0] OFF_MONTH = 8'h14;
   localparam logic [7:0] OFF_YEAR = 8'h18;
   localparam logic [7:0] OFF_CONTROL = 8'h1C;
   localparam logic [7:0] OFF_PRESCALER = 8'h20;

   // Readable/writable bit masks per counter
   localparam logic [7:0] MASK_SECOND = 8'h7F;
   localparam logic [7:0] MASK_MINUTE = 8'h7F;
   localparam logic [7:0] MASK_HOUR = 8'h3F;
   localparam logic [7:0] MASK_WEEKDAY = 8'h07;
   localparam logic [7:0] MASK_DATE = 8'h3F;
   localparam logic [7:0] MASK_MONTH = 8'h1F;

   // Control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Counter limits in BCD
   localparam logic [7:0] BCD_59 = 8'h59;
   localparam logic [7:0] BCD_23 = 8'h23;
   localparam logic [7:0] BCD_12 = 8'h12;
   localparam logic [7:0] BCD_01 = 8'h01;
   localparam logic [7:0] BCD_02 = 8'h02;
   localparam logic [7:0] BCD_28 = 8'h28;
   localparam logic [7:0] BCD_29 = 8'h29;
   localparam logic [7:0] BCD_30 = 8'h30;
   localparam logic [7:0] BCD_31 = 8'h31;
   localparam logic [2:0] WEEKDAY_LAST = 3'h6;

   // Prescaler: 128 steps per second, so bit 0 squares at 64 Hz and bit 6 at 1 Hz
   localparam logic [6:0] PRESCALE_LAST = 7'h7F;
   localparam int TICK_HZ = 128;
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;

   // Calendar time as one carrier
   typedef struct packed {
      logic [15:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] weekday;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } calendar_s;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

endpackage : rtc_cal_pkg

// ==== core/bcd_step.sv ====
`timescale 1ns/1ps
// One BCD counter step: advance with wrap from last to first value
module bcd_step (
   input wire logic [7:0] value,
   input wire logic [7:0] last,
   input wire logic [7:0] first,
   output logic [7:0] next,
   output logic wrap
);

   ////////////////////////////////////////////////////////////////////
   // Units digit rolls into tens at nine
   always_comb begin
      wrap = (value == last);
      if (wrap) begin
         next = first;
      end else if (value[3:0] == 4'h9) begin
         next = {value[7:4] + 4'h1, 4'h0};
      end else begin
         next = {value[7:4], value[3:0] + 4'h1};
      end
   end

endmodule : bcd_step

// ==== core/rtc_calendar.sv ====
`timescale 1ns/1ps
// Function
// - Minute counter advances one BCD step on each minute carry, range 0-59.
// - Minute tens in bits 6:4, units in 3:0; bit 7 reads zero.
// - Hour counter advances on each hour carry, 24-hour range 0-23.
// - Hour tens in bits 5:4, units in 3:0; bits 7:6 read zero.
// - Weekday counter advances on each daily carry, cycling 0 to 6.
// - Weekday in bits 2:0, 0 Sunday to 6 Saturday; bits 7:3 zero.
// - Date counter advances on each daily carry, range 1-31 by month.
// - Date tens in bits 5:4, units in 3:0; bits 7:6 read zero.
// - Month counter advances on each monthly carry, range 1-12.
// - Month tens in bit 4, units in 3:0; bits 7:5 read zero.
// - Year is four BCD digits 0000-9999, advanced by yearly carry.
// - Year digits sit in nibbles 15:12, 11:8, 7:4, 3:0; all writable.
// - Leap year when year divisible by four; 0000 is leap.
// - Calendar counters keep their values through every reset.
// - Second counter counts 0-59 on each one-second prescaler carry.
module rtc_calendar #(
   parameter int TICK_DIV = rtc_cal_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic running,
   output logic second_pulse
);

   ////////////////////////////////////////////////////////////////////
   // All state of this block
   typedef struct packed {
      rtc_cal_pkg::calendar_s cal;
      logic [6:0] prescale;
      logic [31:0] tick_cnt;
      logic [7:0] control;
      logic [31:0] rdata;
      logic second_pulse;
   } state_s;

   state_s s_q;
   state_s s_d;
   rtc_cal_pkg::bus_req_s req;

   logic tick;
   logic sec_carry;
   logic [7:0] sec_next;
   logic min_carry;
   logic [7:0] min_next;
   logic hour_carry;
   logic [7:0] hour_next;
   logic [7:0] wk_next;
   logic wk_wrap;
   logic date_carry;
   logic [7:0] date_next;
   logic [7:0] date_last;
   logic mon_carry;
   logic [7:0] mon_next;
   logic [3:0] yr_next [4];
   logic [3:0] yr_wrap;
   logic leap;
   logic start;
   logic [2:0] leap_sum;
   logic min_step;
   logic hour_step;
   logic day_step;
   logic mon_step;
   logic year_step;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign start = s_q.control[rtc_cal_pkg::CTRL_START_BIT];

   ////////////////////////////////////////////////////////////////////
   // Prescaler step enable, twice the rate of its 64 Hz bit
   // A halted divider keeps its phase; the clear bit restarts it
   assign tick = start && (s_q.tick_cnt == 32'(TICK_DIV - 1));

   assign sec_carry = tick && (s_q.prescale == rtc_cal_pkg::PRESCALE_LAST);

   ////////////////////////////////////////////////////////////////////
   // BCD steps; carries only ripple where the lower counter wrapped
   // wrap at maximum
   // Second wraps 59 to 00 and feeds the minute carry
   bcd_step u_sec (
      .value(s_q.cal.second),
      .last(rtc_cal_pkg::BCD_59),
      .first(8'h00),
      .next(sec_next),
      .wrap()
   );

   bcd_step u_min (
      .value(s_q.cal.minute),
      .last(rtc_cal_pkg::BCD_59),
      .first(8'h00),
      .next(min_next),
      .wrap(min_carry)
   );

   bcd_step u_hour (
      .value(s_q.cal.hour),
      .last(rtc_cal_pkg::BCD_23),
      .first(8'h00),
      .next(hour_next),
      .wrap(hour_carry)
   );

   bcd_step u_mon (
      .value(s_q.cal.month),
      .last(rtc_cal_pkg::BCD_12),
      .first(rtc_cal_pkg::BCD_01),
      .next(mon_next),
      .wrap(mon_carry)
   );

   bcd_step u_date (
      .value(s_q.cal.date),
      .last(date_last),
      .first(rtc_cal_pkg::BCD_01),
      .next(date_next),
      .wrap(date_carry)
   );

   // divisible by four
   // Tens parity decides: 10*t + u is a multiple of 4 iff (2t + u) is
   // Century digits never matter, so 2100 counts as leap as well
   assign leap_sum = {1'b0, s_q.cal.year[4], 1'b0} + {1'b0, s_q.cal.year[1:0]};
   assign leap = (leap_sum[1:0] == 2'h0);

   // Last day of current month
   // Month codes outside 1-12 are illegal; they fall back to 31 days
   always_comb begin
      unique case (s_q.cal.month)
         8'h01: date_last = rtc_cal_pkg::BCD_31;
         8'h02: date_last = leap ? rtc_cal_pkg::BCD_29 : rtc_cal_pkg::BCD_28;
         8'h03: date_last = rtc_cal_pkg::BCD_31;
         8'h04: date_last = rtc_cal_pkg::BCD_30;
         8'h05: date_last = rtc_cal_pkg::BCD_31;
         8'h06: date_last = rtc_cal_pkg::BCD_30;
         8'h07: date_last = rtc_cal_pkg::BCD_31;
         8'h08: date_last = rtc_cal_pkg::BCD_31;
         8'h09: date_last = rtc_cal_pkg::BCD_30;
         8'h10: date_last = rtc_cal_pkg::BCD_31;
         8'h11: date_last = rtc_cal_pkg::BCD_30;
         8'h12: date_last = rtc_cal_pkg::BCD_31;
         default: date_last = rtc_cal_pkg::BCD_31;
      endcase
   end

   assign wk_wrap = (s_q.cal.weekday[2:0] == rtc_cal_pkg::WEEKDAY_LAST);
   assign wk_next = wk_wrap ? 8'h00 : {5'h00, s_q.cal.weekday[2:0] + 3'h1};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_year
         assign yr_wrap[g] = (s_q.cal.year[g*4 +: 4] == 4'h9);
         assign yr_next[g] = yr_wrap[g] ? 4'h0 : s_q.cal.year[g*4 +: 4] + 4'h1;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Carry chain: a counter steps only when every counter below wraps
   // minute on second wrap
   assign min_step = sec_carry && (s_q.cal.second == rtc_cal_pkg::BCD_59);
   assign hour_step = min_step && min_carry;
   // weekday and date share the daily carry
   assign day_step = hour_step && hour_carry;
   assign mon_step = day_step && date_carry;
   assign year_step = mon_step && mon_carry;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic: counting, register writes, read data
   always_comb begin
      s_d = s_q;
      s_d.second_pulse = 1'b0;
      s_d.rdata = 32'h0000_0000;
      // Divider runs only while started
      if (start) begin
         s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h1;
      end
      if (tick) begin
         s_d.prescale = s_q.prescale + 7'h01;
      end
      if (sec_carry) begin
         s_d.second_pulse = 1'b1;
         s_d.cal.second = sec_next;
      end
      if (min_step) begin
         s_d.cal.minute = min_next;
      end
      if (hour_step) begin
         s_d.cal.hour = hour_next;
      end
      // Weekday and date move together on the daily carry
      if (day_step) begin
         s_d.cal.weekday = wk_next;
         s_d.cal.date = date_next;
      end
      if (mon_step) begin
         s_d.cal.month = mon_next;
      end
      // Year ripples digit by digit, 9999 wraps to 0000
      if (year_step) begin
         s_d.cal.year[3:0] = yr_next[0];
         if (yr_wrap[0]) begin
            s_d.cal.year[7:4] = yr_next[1];
         end
         if (yr_wrap[0] && yr_wrap[1]) begin
            s_d.cal.year[11:8] = yr_next[2];
         end
         if (&yr_wrap[2:0]) begin
            s_d.cal.year[15:12] = yr_next[3];
         end
      end
      // writes win over counting; software halts first
      if (req.wr) begin
         unique case (req.addr)
            rtc_cal_pkg::OFF_SECOND:
               s_d.cal.second = req.wdata[7:0] & rtc_cal_pkg::MASK_SECOND;
            rtc_cal_pkg::OFF_MINUTE:
               s_d.cal.minute = req.wdata[7:0] & rtc_cal_pkg::MASK_MINUTE;
            rtc_cal_pkg::OFF_HOUR:
               s_d.cal.hour = req.wdata[7:0] & rtc_cal_pkg::MASK_HOUR;
            rtc_cal_pkg::OFF_WEEKDAY:
               s_d.cal.weekday = req.wdata[7:0] & rtc_cal_pkg::MASK_WEEKDAY;
            rtc_cal_pkg::OFF_DATE:
               s_d.cal.date = req.wdata[7:0] & rtc_cal_pkg::MASK_DATE;
            rtc_cal_pkg::OFF_MONTH:
               s_d.cal.month = req.wdata[7:0] & rtc_cal_pkg::MASK_MONTH;
            rtc_cal_pkg::OFF_YEAR:
               s_d.cal.year = req.wdata[15:0];
            rtc_cal_pkg::OFF_CONTROL: begin
               s_d.control = {6'h00, 1'b0, req.wdata[rtc_cal_pkg::CTRL_START_BIT]};
               // Clear is a strobe, never stored; reads show the start bit only
               // Clear bit restarts the sub-second divider
               if (req.wdata[rtc_cal_pkg::CTRL_CLEAR_BIT]) begin
                  s_d.prescale = 7'h00;
                  s_d.tick_cnt = 32'h0000_0000;
               end
            end
            default: begin
            end
         endcase
      end
      // Read data, unmapped reads return zero
      if (req.rd) begin
         unique case (req.addr)
            rtc_cal_pkg::OFF_SECOND: s_d.rdata = {24'h0, s_q.cal.second};
            rtc_cal_pkg::OFF_MINUTE: s_d.rdata = {24'h0, s_q.cal.minute};
            rtc_cal_pkg::OFF_HOUR: s_d.rdata = {24'h0, s_q.cal.hour};
            rtc_cal_pkg::OFF_WEEKDAY: s_d.rdata = {24'h0, s_q.cal.weekday};
            rtc_cal_pkg::OFF_DATE: s_d.rdata = {24'h0, s_q.cal.date};
            rtc_cal_pkg::OFF_MONTH: s_d.rdata = {24'h0, s_q.cal.month};
            rtc_cal_pkg::OFF_YEAR: s_d.rdata = {16'h0, s_q.cal.year};
            rtc_cal_pkg::OFF_CONTROL: s_d.rdata = {24'h0, s_q.control};
            rtc_cal_pkg::OFF_PRESCALER: s_d.rdata = {25'h0, s_q.prescale};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reset leaves calendar and prescaler untouched
   // Only control, the divider count and bus outputs have reset values
   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
      if (rst) begin
         s_q.control <= rtc_cal_pkg::CTRL_RESET;
         s_q.tick_cnt <= 32'h0000_0000;
         s_q.rdata <= 32'h0000_0000;
         s_q.second_pulse <= 1'b0;
      end
   end

   // Outputs come straight from the state register
   assign rdata = s_q.rdata;
   assign running = s_q.control[rtc_cal_pkg::CTRL_START_BIT];
   assign second_pulse = s_q.second_pulse;

endmodule : rtc_calendar

// ==== tb/rtc_calendar_chk.sv ====
`timescale 1ns/1ps
module rtc_calendar_chk #(
   parameter int TICK_DIV = rtc_cal_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic running,
   input wire logic second_pulse
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Read data stands one cycle only, so a stale value cannot be mistaken for fresh
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read slot");
   AST_RUN_SET: assert property (wr && addr == rtc_cal_pkg::OFF_CONTROL
      |=> running == $past(wdata[0]))
      else $error("start bit not taken");
   AST_RUN_HOLD: assert property (!(wr && addr == rtc_cal_pkg::OFF_CONTROL)
      |=> $stable(running))
      else $error("start bit moved alone");
   AST_PULSE_RUN: assert property (second_pulse |-> $past(running) && !$past(second_pulse))
      else $error("second advanced while stopped");
   // Reserved bits of each counter except the second read back as zero
   AST_MIN_RSVD: assert property ($past(rd) && $past(addr) == rtc_cal_pkg::OFF_MINUTE
      |-> rdata[31:7] == 25'h0)
      else $error("minute reserved bits set");
   AST_HOUR_RSVD: assert property ($past(rd) && $past(addr) == rtc_cal_pkg::OFF_HOUR
      |-> rdata[31:6] == 26'h0)
      else $error("hour reserved bits set");
   AST_WDAY_RSVD: assert property ($past(rd) && $past(addr) == rtc_cal_pkg::OFF_WEEKDAY
      |-> rdata[31:3] == 29'h0)
      else $error("weekday reserved bits set");
   AST_DATE_RSVD: assert property ($past(rd) && $past(addr) == rtc_cal_pkg::OFF_DATE
      |-> rdata[31:6] == 26'h0)
      else $error("date reserved bits set");
   AST_MON_RSVD: assert property ($past(rd) && $past(addr) == rtc_cal_pkg::OFF_MONTH
      |-> rdata[31:5] == 27'h0)
      else $error("month reserved bits set");
   AST_YEAR_RSVD: assert property ($past(rd) && $past(addr) == rtc_cal_pkg::OFF_YEAR
      |-> rdata[31:16] == 16'h0)
      else $error("year upper half set");
endmodule : rtc_calendar_chk

bind rtc_calendar rtc_calendar_chk #(.TICK_DIV(TICK_DIV)) rtc_calendar_chk_i (.clk_sys(clk_sys),
   .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .running(running),
   .second_pulse(second_pulse));

// ==== tb/test_rtc_calendar_counter_chain.sv ====
`timescale 1ns/1ps
module test_rtc_calendar_counter_chain;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic running;
   logic second_pulse;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   // Short divider keeps one second near 256 cycles
   rtc_calendar #(.TICK_DIV(2)) rtc_calendar_i (.clk_sys(clk_sys), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .running(running),
      .second_pulse(second_pulse));
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      cmp(rdata, e, "read");
   endtask : rd_chk
   // Counter i sits at offset 4*i, year last and 16 bits wide
   function automatic logic [31:0] field(input logic [63:0] t, input int i);
      return (i < 6) ? {24'h0, t[8*i +: 8]} : {16'h0, t[63:48]};
   endfunction : field
   task automatic set_time(input logic [63:0] t);
      for (int i = 0; i < 7; i++) wr_reg(8'(4 * i), field(t, i));
   endtask : set_time
   task automatic chk_time(input logic [63:0] t);
      for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), field(t, i));
   endtask : chk_time
   // Clear the divider on start so the advance lands at a known distance
   task automatic roll(input logic [63:0] from, input logic [63:0] to);
      int n;
      n = 0;
      set_time(from);
      wr_reg(rtc_cal_pkg::OFF_CONTROL, 32'h3);
      #1;
      cmp({31'h0, running}, 32'h1, "running");
      while (second_pulse !== 1'b1 && n < 400) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      cmp({31'h0, second_pulse}, 32'h1, "second pulse");
      wr_reg(rtc_cal_pkg::OFF_CONTROL, 32'h0);
      rd_chk(rtc_cal_pkg::OFF_CONTROL, 32'h0);
      cmp({31'h0, running}, 32'h0, "stopped");
      chk_time(to);
   endtask : roll
   task automatic day(input logic [15:0] y, input logic [7:0] m, d, w,
                      input logic [15:0] y2, input logic [7:0] m2, d2, w2);
      roll({y, m, d, w, 24'h235959}, {y2, m2, d2, w2, 24'h000000});
   endtask : day
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_hours();
      roll(64'h2024_05_14_02_10_12_59, 64'h2024_05_14_02_10_13_00);
      roll(64'h2024_05_14_02_09_59_59, 64'h2024_05_14_02_10_00_00);
      day(16'h2023, 8'h04, 8'h30, 8'h06, 16'h2023, 8'h05, 8'h01, 8'h00);
      $display("test_hours done");
   endtask : test_hours
   task automatic test_february();
      day(16'h2024, 8'h02, 8'h28, 8'h03, 16'h2024, 8'h02, 8'h29, 8'h04);
      day(16'h2024, 8'h02, 8'h29, 8'h04, 16'h2024, 8'h03, 8'h01, 8'h05);
      day(16'h2023, 8'h02, 8'h28, 8'h02, 16'h2023, 8'h03, 8'h01, 8'h03);
      day(16'h0000, 8'h02, 8'h28, 8'h01, 16'h0000, 8'h02, 8'h29, 8'h02);
      day(16'h2100, 8'h02, 8'h28, 8'h00, 16'h2100, 8'h02, 8'h29, 8'h01);
      day(16'h2012, 8'h02, 8'h28, 8'h02, 16'h2012, 8'h02, 8'h29, 8'h03);
      day(16'h2010, 8'h02, 8'h28, 8'h00, 16'h2010, 8'h03, 8'h01, 8'h01);
      $display("test_february done");
   endtask : test_february
   task automatic test_months();
      day(16'h2024, 8'h01, 8'h31, 8'h03, 16'h2024, 8'h02, 8'h01, 8'h04);
      day(16'h2024, 8'h09, 8'h30, 8'h01, 16'h2024, 8'h10, 8'h01, 8'h02);
      day(16'h1999, 8'h12, 8'h31, 8'h05, 16'h2000, 8'h01, 8'h01, 8'h06);
      $display("test_months done");
   endtask : test_months
   // All-ones writes show which bits each counter keeps
   task automatic test_layout();
      logic [31:0] m [7] = '{32'h7F, 32'h7F, 32'h3F, 32'h07, 32'h3F, 32'h1F, 32'hFFFF};
      for (int i = 0; i < 7; i++) begin
         wr_reg(8'(4 * i), 32'hFFFF_FFFF);
         rd_chk(8'(4 * i), m[i]);
      end
      wr_reg(8'h24, 32'h5A);
      rd_chk(8'h24, 32'h0);
      $display("test_layout done");
   endtask : test_layout
   task automatic test_retain();
      set_time(64'h4321_11_27_05_13_45_38);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      chk_time(64'h4321_11_27_05_13_45_38);
      $display("test_retain done");
   endtask : test_retain
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard, well above the roughly 3800 cycles the tests need
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      test_layout();
      test_hours();
      test_february();
      test_months();
      test_retain();
      results();
   end
endmodule : test_rtc_calendar_counter_chain
